/* File: core/sas_defs.vh */
// register map, field positions and timing counts for the converter sequencer
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH

// =====================================================================
// register byte offsets
`define SAS_OFS_CTRL_FIRST   5'h00
`define SAS_OFS_CTRL_SECOND  5'h04
`define SAS_OFS_RES_HIGH     5'h08
`define SAS_OFS_RES_LOW      5'h0C
`define SAS_OFS_INT_CTRL     5'h10

// =====================================================================
// converter_control_first fields
`define SAS_F1_START         7
`define SAS_F1_BUSY          6
`define SAS_F1_POWER         5
`define SAS_F1_FORMAT        4
`define SAS_F1_CHAN_HI       3
`define SAS_F1_CHAN_LO       0

// converter_control_second fields
`define SAS_F2_INSEL_HI      7
`define SAS_F2_INSEL_LO      5
`define SAS_F2_REF_HI        4
`define SAS_F2_REF_LO        3
`define SAS_F2_DIV_HI        2
`define SAS_F2_DIV_LO        0

// interrupt control fields
`define SAS_FI_GLOBAL        0
`define SAS_FI_ENABLE        1
`define SAS_FI_FLAG          2

// =====================================================================
// internal signal select codes
`define SAS_INSEL_NONE       3'h0
`define SAS_INSEL_BANDGAP    3'h1
`define SAS_INSEL_TEMP       3'h2
`define SAS_INSEL_EXT_A      3'h5
`define SAS_INSEL_EXT_B      3'h6

// =====================================================================
// reset values and timing in converter clock cycles
`define SAS_RST_BYTE         8'h00
`define SAS_RST_RESULT       12'h000
`define SAS_SAR_TOP          12'h800
`define SAS_CONV_CYC         6'h0C
`define SAS_TOTAL_EXT        6'h10
`define SAS_TOTAL_TEMP       6'h38
`define SAS_BIT_TOP          4'hB

`endif

/* File: core/sas_clk_div.v */
// converter clock divider: one-cycle tick every 2^select system clocks
`timescale 1ns/1ps
`default_nettype none
module sas_clk_div #(
  parameter SEL_W = 3
) (
  // clock and reset
  input  wire             clock_in,
  input  wire             resetn_in,
  // control
  input  wire             run_in,
  input  wire [SEL_W-1:0] select_in,
  // tick
  output wire             tick_out
);
  localparam CNT_W = (1 << SEL_W) - 1;

  reg  [CNT_W-1:0] count_r;
  wire [CNT_W-1:0] mask = ~({CNT_W{1'b1}} << select_in);

  // =====================================================================
  // free count, restarted whenever the converter is stopped
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_r <= {CNT_W{1'b0}};
    end else if (!run_in) begin
      count_r <= {CNT_W{1'b0}};
    end else begin
      count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // divide by 1, 2, 4 ... 128 for codes 000 to 111
  assign tick_out = run_in & ((count_r & mask) == mask);
endmodule // sas_clk_div
`default_nettype wire

/* File: core/sas_res_fmt.v */
// packs the 12-bit result into the high and low result bytes
`timescale 1ns/1ps
`default_nettype none
module sas_res_fmt (
  // input
  input  wire [11:0] code_in,
  input  wire        format_in,
  // packed bytes
  output wire [7:0]  high_out,
  output wire [7:0]  low_out
);
  // format 0: left justified, format 1: right justified
  assign high_out = format_in ? {4'h0, code_in[11:8]} : code_in[11:4];
  assign low_out  = format_in ? code_in[7:0] : {code_in[3:0], 4'h0};
endmodule // sas_res_fmt
`default_nettype wire

/* File: core/sas_adc_seq.v */
// successive-approximation converter sequencer with Avalon-MM registers
//
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.vh"
module sas_adc_seq (
  // clock and reset
  input  wire        clock_in,
  input  wire        resetn_in,
  // avalon-mm slave
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  // analog front end
  input  wire        comparator_in,
  output wire        power_enable_out,
  output wire        sample_out,
  output wire [11:0] dac_code_out,
  output wire [3:0]  external_channel_select_out,
  output wire        external_connect_out,
  output wire [2:0]  internal_signal_select_out,
  output wire [1:0]  reference_source_select_out,
  // interrupt
  output wire        irq_out
);
  // =====================================================================
  // states
  localparam ST_IDLE   = 2'b00;
  localparam ST_SAMPLE = 2'b01;
  localparam ST_CONV   = 2'b10;

  // =====================================================================
  // registers
  reg        start_r;
  reg        start_d_r;
  reg        power_r;
  reg        format_r;
  reg  [3:0] chan_r;
  reg  [2:0] insel_r;
  reg  [1:0] ref_r;
  reg  [2:0] div_r;
  reg        gie_r;
  reg        cie_r;
  reg        flag_r;
  reg        busy_r;
  reg  [1:0] state_r;
  reg  [5:0] cnt_r;
  reg  [3:0] bit_r;
  reg [11:0] sar_r;
  reg  [7:0] res_high_r;
  reg  [7:0] res_low_r;
  reg        ack_r;

  wire       tick;
  wire [7:0] fmt_high;
  wire [7:0] fmt_low;
  wire       wr_take = avs_write_in & ack_r;
  wire       wr_first = wr_take & (avs_address_in == `SAS_OFS_CTRL_FIRST);
  wire       wr_second = wr_take & (avs_address_in == `SAS_OFS_CTRL_SECOND);
  wire       wr_int = wr_take & (avs_address_in == `SAS_OFS_INT_CTRL);
  wire       start_rise = start_r & ~start_d_r;
  wire       start_fall = ~start_r & start_d_r;
  wire       temp_sel = (insel_r == `SAS_INSEL_TEMP);
  wire [5:0] sample_len = (temp_sel ? `SAS_TOTAL_TEMP : `SAS_TOTAL_EXT) - `SAS_CONV_CYC;
  wire [11:0] trial = `SAS_SAR_TOP >> (`SAS_BIT_TOP - bit_r);
  wire       last_bit = (bit_r == 4'h0);
  wire       done = (state_r == ST_CONV) & tick & last_bit;
  wire [11:0] final_code = comparator_in ? sar_r : (sar_r & ~trial);

  // =====================================================================
  // converter clock and result packing
  sas_clk_div #(
    .SEL_W     (3)
  ) u_div (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .run_in    (power_r & (state_r != ST_IDLE)),
    .select_in (div_r),
    .tick_out  (tick)
  );

  sas_res_fmt u_fmt (
    .code_in   (final_code),
    .format_in (format_r),
    .high_out  (fmt_high),
    .low_out   (fmt_low)
  );

  // =====================================================================
  // bus slave: one wait cycle per access, so the cpu is only held for
  // the access itself and never for the conversion
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;

  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_r            <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
      if (avs_read_in & ~ack_r) begin
        case (avs_address_in)
          `SAS_OFS_CTRL_FIRST: begin
            // busy is read here for polling
            avs_readdata_out <= {24'h00_0000, start_r, busy_r, power_r,
                                 format_r, chan_r};
          end
          `SAS_OFS_CTRL_SECOND: begin
            avs_readdata_out <= {24'h00_0000, insel_r, ref_r, div_r};
          end
          `SAS_OFS_RES_HIGH: begin
            avs_readdata_out <= {24'h00_0000, res_high_r};
          end
          `SAS_OFS_RES_LOW: begin
            avs_readdata_out <= {24'h00_0000, res_low_r};
          end
          `SAS_OFS_INT_CTRL: begin
            avs_readdata_out <= {29'h0000_0000, flag_r, cie_r, gie_r};
          end
          default: begin
            avs_readdata_out <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // =====================================================================
  // control registers
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start_r   <= 1'b0;
      start_d_r <= 1'b0;
      power_r   <= 1'b0;
      format_r  <= 1'b0;
      chan_r    <= 4'h0;
      insel_r   <= `SAS_INSEL_NONE;
      ref_r     <= 2'h0;
      div_r     <= 3'h0;
      gie_r     <= 1'b0;
      cie_r     <= 1'b0;
    end else begin
      start_d_r <= start_r;
      if (wr_first) begin
        // 20H: power on, external input zero
        start_r  <= avs_writedata_in[`SAS_F1_START];
        power_r  <= avs_writedata_in[`SAS_F1_POWER];
        format_r <= avs_writedata_in[`SAS_F1_FORMAT];
        chan_r   <= avs_writedata_in[`SAS_F1_CHAN_HI:`SAS_F1_CHAN_LO];
      end
      if (wr_second) begin
        insel_r <= avs_writedata_in[`SAS_F2_INSEL_HI:`SAS_F2_INSEL_LO];
        ref_r   <= avs_writedata_in[`SAS_F2_REF_HI:`SAS_F2_REF_LO];
        div_r   <= avs_writedata_in[`SAS_F2_DIV_HI:`SAS_F2_DIV_LO];
      end
      if (wr_int) begin
        gie_r <= avs_writedata_in[`SAS_FI_GLOBAL];
        cie_r <= avs_writedata_in[`SAS_FI_ENABLE];
      end
    end
  end

  // =====================================================================
  // request flag: completion wins over a clearing write
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flag_r <= 1'b0;
    end else if (done) begin
      flag_r <= 1'b1;
    end else if (wr_int & ~avs_writedata_in[`SAS_FI_FLAG]) begin
      flag_r <= 1'b0;
    end
  end

  assign irq_out = flag_r & gie_r & cie_r;

  // =====================================================================
  // conversion sequencer
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r    <= ST_IDLE;
      busy_r     <= 1'b0;
      cnt_r      <= 6'h00;
      bit_r      <= `SAS_BIT_TOP;
      sar_r      <= `SAS_RST_RESULT;
      res_high_r <= `SAS_RST_BYTE;
      res_low_r  <= `SAS_RST_BYTE;
    end else if (!power_r) begin
      // powered down: abandon any conversion
      state_r <= ST_IDLE;
      busy_r  <= 1'b0;
    end else if (start_rise) begin
      // rising start edge resets the conversion logic
      state_r <= ST_IDLE;
      busy_r  <= 1'b0;
    end else if (start_fall) begin
      // falling start edge begins sampling, busy set
      state_r <= ST_SAMPLE;
      busy_r  <= 1'b1;
      cnt_r   <= 6'h00;
    end else begin
      case (state_r)
        ST_SAMPLE: begin
          if (tick) begin
            // 4 cycles external, 44 for temperature
            if (cnt_r == sample_len - 6'h01) begin
              state_r <= ST_CONV;
              bit_r   <= `SAS_BIT_TOP;
              sar_r   <= `SAS_SAR_TOP;
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
        end
        ST_CONV: begin
          if (tick) begin
            // one bit per converter cycle, 12 cycles
            if (last_bit) begin
              state_r    <= ST_IDLE;
              busy_r     <= 1'b0;
              sar_r      <= final_code;
              // both bytes load in the same edge
              res_high_r <= fmt_high;
              res_low_r  <= fmt_low;
            end else begin
              sar_r <= final_code | (trial >> 1);
              bit_r <= bit_r - 4'h1;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // input routing decode
  reg        ext_permit;

  // an internal source shares the converter input with the pins, so the
  // pins may only be connected for the select codes that leave them free;
  // a software slip then cannot short an internal signal onto a pin
  always @* begin
    case (insel_r)
      `SAS_INSEL_NONE: begin
        ext_permit = 1'b1;
      end
      `SAS_INSEL_EXT_A: begin
        ext_permit = 1'b1;
      end
      `SAS_INSEL_EXT_B: begin
        ext_permit = 1'b1;
      end
      default: begin
        ext_permit = 1'b0;
      end
    endcase
  end

  // =====================================================================
  // analog side controls
  // limitation: the divider restarts at every start, so the first
  // converter cycle is a full period long whatever the bus timing was
  assign power_enable_out            = power_r;
  assign sample_out                  = (state_r == ST_SAMPLE);
  assign dac_code_out                = sar_r;
  assign external_channel_select_out = chan_r;
  assign internal_signal_select_out  = insel_r;
  assign reference_source_select_out = ref_r;
  // external pin connected only for a 0xxx channel and a permitting select
  assign external_connect_out = ~chan_r[3] & ext_permit;
endmodule // sas_adc_seq
`default_nettype wire

/* File: tb/sas_adc_seq_properties.sv */
// port assertions for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sas_adc_seq_properties (
  // clock, reset and bus
  input wire logic        clock_in,
  input wire logic        resetn_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // converter side
  input wire logic        power_enable_out,
  input wire logic        sample_out,
  input wire logic [3:0]  external_channel_select_out,
  input wire logic        external_connect_out,
  input wire logic [2:0]  internal_signal_select_out
);
  // ==========
  // assertions
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  wait_first_a: assert property (
    $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("no wait cycle on new access");
  wait_bound_a: assert property (
    avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus stalled beyond one cycle");
  read_upper_a: assert property (
    avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h000000)
    else $error("read data upper bits set");
  connect_sel_a: assert property (
    external_connect_out == (!external_channel_select_out[3] &&
      (internal_signal_select_out inside {3'h0, 3'h5, 3'h6})))
    else $error("external connect wrong");
  power_off_a: assert property (
    $fell(power_enable_out) |-> ##[0:1] !sample_out)
    else $error("sampling kept after power off");
  start_power_a: assert property (
    $rose(sample_out) |-> $past(power_enable_out))
    else $error("sampling began without power");
  sample_len_a: assert property (
    $rose(sample_out) |-> sample_out [*4])
    else $error("sampling shorter than four ticks");
  convert_span_a: assert property (
    $fell(sample_out) && power_enable_out |-> !sample_out [*8])
    else $error("conversion phase cut short");
endmodule // sas_adc_seq_properties

bind sas_adc_seq sas_adc_seq_properties chk_i (
  .clock_in(clock_in), .resetn_in(resetn_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .power_enable_out(power_enable_out), .sample_out(sample_out),
  .external_channel_select_out(external_channel_select_out),
  .external_connect_out(external_connect_out),
  .internal_signal_select_out(internal_signal_select_out)
);
`default_nettype wire

/* File: tb/sas_adc_seq_bench.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.vh"
module sas_adc_seq_bench;
  // ==========
  // signals
  logic        clock_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [11:0] level_r = 12'h000;
  logic [31:0] rnd_r = 32'hE265;
  wire  [31:0] rdat;
  wire         wreq, pwr, smp, conn, irq;
  wire  [11:0] dac;
  wire  [3:0]  chs;
  wire  [2:0]  ins_o;
  wire  [1:0]  ref_o;
  wire         cmp = (level_r >= dac);
  integer      error_cnt = 0;
  integer      tests_run = 0;
  logic [2:0]  dv_t [0:5] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h1, 3'h3};
  logic [2:0]  is_t [0:5] = '{3'h0, 3'h5, 3'h6, 3'h2, 3'h1, 3'h0};
  logic [7:0]  ic_t [0:5] = '{8'h03, 8'h03, 8'h01, 8'h03, 8'h03, 8'h03};

  sas_adc_seq uut (
    .clock_in(clock_in), .resetn_in(resetn_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .comparator_in(cmp), .power_enable_out(pwr),
    .sample_out(smp), .dac_code_out(dac), .external_channel_select_out(chs),
    .external_connect_out(conn), .internal_signal_select_out(ins_o),
    .reference_source_select_out(ref_o), .irq_out(irq)
  );

  always #12.5 clock_in = ~clock_in;

  // ==========
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    integer k;
    @(posedge clock_in);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {24'h000000, d};
    k = 0;
    do begin @(posedge clock_in); k++; end while (wreq !== 1'b0 && k < 50);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) chk("bus answer", 16'h0000, 16'h0001);
  endtask

  // one conversion: configure, pulse start, time it, read the result
  task automatic conv(input logic [2:0] dv, input logic [2:0] ins, input logic fm,
                      input logic [7:0] ic);
    logic [7:0] q;
    logic [3:0] ch;
    logic [11:0] lv;
    integer n, m, sp, tt;
    rnd_r = xs(rnd_r);
    ch = {ins inside {3'h1, 3'h2} || dv == 3'h3, rnd_r[14:12]};
    lv = rnd_r[11:0];
    level_r <= lv;
    sp = ((ins == `SAS_INSEL_TEMP) ? 44 : 4) << dv;
    tt = ((ins == `SAS_INSEL_TEMP) ? 56 : 16) << dv;
    bus(1'b1, `SAS_OFS_CTRL_SECOND, {ins, rnd_r[17:16], dv}, q);
    bus(1'b1, `SAS_OFS_INT_CTRL, ic, q);
    bus(1'b1, `SAS_OFS_CTRL_FIRST, {3'b101, fm, ch}, q);
    bus(1'b1, `SAS_OFS_CTRL_FIRST, {3'b001, fm, ch}, q);
    #1;
    chk("connect", {15'h0, !ch[3] && (ins inside {3'h0, 3'h5, 3'h6})}, {15'h0, conn});
    chk("reference", {14'h0, rnd_r[17:16]}, {14'h0, ref_o});
    n = 0;
    while (smp !== 1'b1 && n < 9) begin @(posedge clock_in); #1; n++; end
    n = 0;
    do begin @(posedge clock_in); #1; n++; end while (smp === 1'b1 && n < 6000);
    m = n;
    if (ic[1]) begin
      while (irq !== 1'b1 && m < 9000) begin @(posedge clock_in); #1; m++; end
      chk("sample cycles", 16'(sp), 16'(n));
      chk("total cycles", 16'(tt), 16'(m));
    end else begin
      bus(1'b0, `SAS_OFS_CTRL_FIRST, 8'h00, q);
      chk("busy", 16'h0040, {8'h00, q & 8'h40});
      while (q[6] === 1'b1 && m < 9000) begin bus(1'b0, 5'h00, 8'h00, q); m++; end
      chk("masked irq", 16'h0000, {15'h0, irq});
      bus(1'b1, `SAS_OFS_INT_CTRL, 8'h07, q);
      #1;
      chk("irq", 16'h0001, {15'h0, irq});
    end
    bus(1'b0, `SAS_OFS_CTRL_FIRST, 8'h00, q);
    chk("idle control", {8'h00, 3'b001, fm, ch}, {8'h00, q});
    bus(1'b0, `SAS_OFS_RES_LOW, 8'h00, q);
    chk("low byte", {8'h00, fm ? lv[7:0] : {lv[3:0], 4'h0}}, {8'h00, q});
    bus(1'b0, `SAS_OFS_RES_HIGH, 8'h00, q);
    chk("high byte", {8'h00, fm ? {4'h0, lv[11:8]} : lv[11:4]}, {8'h00, q});
    bus(1'b1, `SAS_OFS_INT_CTRL, 8'h03, q);
    #1;
    chk("irq cleared", 16'h0000, {15'h0, irq});
  endtask

  // ==========
  // sequence
  initial begin
    logic [7:0] q;
    integer i;
    repeat (12) @(posedge clock_in);
    resetn_in <= 1'b1;
    for (i = 0; i < 6; i++) begin
      bus(1'b0, 5'(i * 4), 8'h00, q);
      chk("reset value", 16'h0000, {8'h00, q});
    end
    bus(1'b1, `SAS_OFS_CTRL_FIRST, 8'h20, q);
    #1;
    chk("power on", 16'h0003, {14'h0, pwr, conn});
    chk("channel", 16'h0000, {12'h0, chs});
    for (i = 0; i < 6; i++) conv(dv_t[i], is_t[i], i[0], ic_t[i]);
    bus(1'b1, `SAS_OFS_CTRL_FIRST, 8'hA0, q);
    bus(1'b1, `SAS_OFS_CTRL_FIRST, 8'h20, q);
    repeat (20) @(posedge clock_in);
    bus(1'b1, `SAS_OFS_CTRL_FIRST, 8'h00, q);
    repeat (2) @(posedge clock_in);
    #1;
    chk("abort", 16'h0000, {14'h0, pwr, smp});
    end_of_test();
  end

  // watchdog well beyond the longest expected run
  initial begin
    #(25 * 20000);
    error_cnt++;
    end_of_test();
  end
endmodule // sas_adc_seq_bench
`default_nettype wire
